//--- cwnp_pkg.sv
// cwnp_pkg: constants, modes and carriers for the config word loader
// assumes 14-bit word images arriving from the flash array
package cwnp_pkg;
  localparam int WORD_W = 14;
  localparam int BSZ_W = 16;
  localparam logic [7:0] ADR_WDOG = 8'h00;
  localparam logic [7:0] ADR_MEM = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0C;
  localparam logic [13:0] WDOG_UNIMPL = 14'h0080;
  localparam logic [13:0] MEM_UNIMPL = 14'h1460;
  localparam logic [13:0] MEM_STICKY = 14'h0B98;
  localparam int CLKSEL_LSB = 11;
  localparam int WIN_LSB = 8;
  localparam int MODE_LSB = 5;
  localparam int PER_LSB = 0;
  localparam int LV_PROG_BIT = 13;
  localparam int SA_WP_BIT = 11;
  localparam int CFG_WP_BIT = 9;
  localparam int BOOT_WP_BIT = 8;
  localparam int APP_WP_BIT = 7;
  localparam int SA_EN_N_BIT = 4;
  localparam int BOOT_EN_N_BIT = 3;
  localparam int BSZ_LSB = 0;
  localparam logic [2:0] WIN_OPEN = 3'h7;
  localparam logic [2:0] WIN_SOFT_MIN = 3'h6;
  localparam logic [4:0] PER_ERASED = 5'h1F;
  localparam logic [4:0] PER_DEFAULT = 5'h0B;
  localparam logic [5:0] PER_SHIFT_BASE = 6'h05;
  localparam logic [2:0] BOOT_SMALL = 3'h7;
  localparam logic [15:0] BOOT_SMALL_WORDS = 16'h0200;
  localparam logic [15:0] BOOT_LARGE_WORDS = 16'h0400;
  localparam int CTL_SOFT_EN = 0;
  localparam int CTL_WIN_LSB = 4;
  localparam int CTL_PER_LSB = 8;
  localparam int STA_REJ = 0;
  localparam int STA_RUN = 1;
  localparam int STA_HELD = 2;
  localparam int STA_PROT_LSB = 8;
  localparam int STA_BSZ_LSB = 16;
  typedef enum logic [2:0] {
    CLK_MF = 3'b000,
    CLK_LF = 3'b001,
    CLK_RSVD = 3'b010,
    CLK_SOFT = 3'b111
  } cwnp_clk_t;
  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_SOFT = 2'b01,
    MODE_AWAKE = 2'b10,
    MODE_ON = 2'b11
  } cwnp_mode_t;
  typedef enum logic {
    ST_LOAD = 1'b0,
    ST_HELD = 1'b1
  } cwnp_state_t;
  typedef struct packed {
    cwnp_clk_t clk_sel;
    logic [2:0] window;
    logic win_soft;
    logic win_keyed;
    cwnp_mode_t mode;
    logic [4:0] period;
    logic per_soft;
    logic [5:0] div_shift;
  } cwnp_wdog_t;
  typedef struct packed {
    logic lv_prog_en;
    logic hv_prog_req;
    logic reset_pin_fixed;
    logic store_en;
    logic store_wp;
    logic cfg_wp;
    logic boot_en;
    logic boot_wp;
    logic app_wp;
    logic [15:0] boot_words;
  } cwnp_prot_t;
  localparam cwnp_wdog_t WDOG_RST = '0;
  localparam cwnp_prot_t PROT_RST = '0;
endpackage

//--- cwnp_config_loader.sv
// cwnp_config_loader: decodes watchdog and memory config words
// assumes word images from the flash array, classic Wishbone master
//
// Overview of operation
// - clock select: 001 low, 000 mid, 111 soft
// - window 11x open and soft, else keyed
// - mode 11 runs always, soft enable ignored
// - mode 10 runs awake, suspended asleep
// - mode 01 follows soft enable only
// - mode 00 keeps watchdog off
// - period codes give divider two^(code+5)
// - erased period loads 01011, software selectable
// - low voltage programming fixes reset pin
// - interface cannot clear low voltage bit
// - storage write protect only when enabled
// - config write protect blocks self writes
// - boot write protect only when enabled
// - app write protect blocks app self writes
// - boot and storage enables are active low
// - boot size locked once boot enabled
// - protection bits clear only, erase restores
// - boot size 0, 512 or 1024 words
// - boot size clamped to half memory
// - unimplemented bits read as one
//
// Decided for this implementation: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module cwnp_config_loader
  import cwnp_pkg::*;
#(
  parameter int UPM_WORDS = 2048,
  parameter int STORE_WORDS = 128,
  parameter int PA_W = 15
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [WORD_W-1:0] nvm_wdog_word,
  input wire logic [WORD_W-1:0] nvm_mem_word,
  input wire logic reset_pin_enable,
  input wire logic lv_iface_active,
  input wire logic prog_access,
  input wire logic core_sleep,
  input wire logic sw_req,
  input wire logic [PA_W-1:0] sw_addr,
  input wire logic sw_cfg,
  output logic sw_deny,
  output logic nvm_wr_valid,
  output logic nvm_wr_mem,
  output logic [WORD_W-1:0] nvm_wr_data,
  output cwnp_wdog_t wdog_cfg,
  output cwnp_prot_t prot_cfg,
  output logic wdog_run,
  output logic [2:0] wdog_window_runtime,
  output logic [4:0] wdog_period_runtime
);
  localparam logic [15:0] HALF_WORDS = 16'(UPM_WORDS / 2);
  localparam logic [PA_W-1:0] STORE_BASE =
    PA_W'(UPM_WORDS - STORE_WORDS);

  cwnp_state_t state_q, state_d;
  cwnp_wdog_t wcfg_q;
  cwnp_prot_t pcfg_q;
  logic [WORD_W-1:0] wimg_q, mimg_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic run_q, run_d;
  logic soft_en_q;
  logic [2:0] win_rt_q;
  logic [4:0] per_rt_q;
  logic rej_q;
  logic wr_valid_q, wr_mem_q;
  logic [WORD_W-1:0] wr_data_q;

  // load sequencing: one capture cycle after reset, then held
  wire load_en = (state_q == ST_LOAD);
  always_comb begin
    case (state_q)
      ST_LOAD: state_d = ST_HELD;
      ST_HELD: state_d = ST_HELD;
      default: state_d = ST_LOAD;
    endcase
  end

  // watchdog word decode
  wire [WORD_W-1:0] w_in = nvm_wdog_word | WDOG_UNIMPL;
  wire [2:0] ccs = w_in[CLKSEL_LSB +: 3];
  wire [2:0] cws = w_in[WIN_LSB +: 3];
  wire [4:0] cps = w_in[PER_LSB +: 5];
  wire ccs_ok = (ccs == CLK_LF) | (ccs == CLK_MF) | (ccs == CLK_SOFT);
  wire w_soft = (cws >= WIN_SOFT_MIN);
  wire p_soft = (cps == PER_ERASED);
  wire [4:0] per = p_soft ? PER_DEFAULT : cps;
  cwnp_wdog_t w_dec;
  assign w_dec.clk_sel = ccs_ok ? cwnp_clk_t'(ccs) : CLK_RSVD;
  assign w_dec.window = w_soft ? WIN_OPEN : cws;
  assign w_dec.win_soft = w_soft;
  assign w_dec.win_keyed = ~w_soft;
  assign w_dec.mode = cwnp_mode_t'(w_in[MODE_LSB +: 2]);
  assign w_dec.period = per;
  assign w_dec.per_soft = p_soft;
  assign w_dec.div_shift = {1'b0, per} + PER_SHIFT_BASE;

  // memory word decode; enables are active low
  wire [WORD_W-1:0] m_in = nvm_mem_word | MEM_UNIMPL;
  wire boot_on = ~m_in[BOOT_EN_N_BIT];
  wire store_on = ~m_in[SA_EN_N_BIT];
  wire [2:0] bsz = m_in[BSZ_LSB +: 3];
  wire [15:0] bsz_raw = ~boot_on ? 16'h0000 :
    (bsz == BOOT_SMALL) ? BOOT_SMALL_WORDS : BOOT_LARGE_WORDS;
  wire [15:0] bsz_clamp =
    (bsz_raw > HALF_WORDS) ? HALF_WORDS : bsz_raw;
  cwnp_prot_t p_dec;
  assign p_dec.lv_prog_en = m_in[LV_PROG_BIT];
  assign p_dec.hv_prog_req = ~m_in[LV_PROG_BIT];
  // reset-pin enable is ignored while low voltage programming is on
  assign p_dec.reset_pin_fixed =
    m_in[LV_PROG_BIT] | reset_pin_enable;
  assign p_dec.store_en = store_on;
  assign p_dec.store_wp = store_on & ~m_in[SA_WP_BIT];
  assign p_dec.cfg_wp = ~m_in[CFG_WP_BIT];
  assign p_dec.boot_en = boot_on;
  assign p_dec.boot_wp = boot_on & ~m_in[BOOT_WP_BIT];
  assign p_dec.app_wp = ~m_in[APP_WP_BIT];
  assign p_dec.boot_words = bsz_clamp;

  // captured once per reset; later flash writes take effect next reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_q <= ST_LOAD;
      wcfg_q <= WDOG_RST;
      pcfg_q <= PROT_RST;
      wimg_q <= '0;
      mimg_q <= '0;
    end else begin
      state_q <= state_d;
      if (load_en) begin
        wcfg_q <= w_dec;
        pcfg_q <= p_dec;
        wimg_q <= w_in;
        mimg_q <= m_in;
      end
    end
  end

  // watchdog run decision, from the latched mode
  always_comb begin
    case (wcfg_q.mode)
      MODE_ON: run_d = 1'b1;
      MODE_AWAKE: run_d = ~core_sleep;
      MODE_SOFT: run_d = soft_en_q;
      MODE_OFF: run_d = 1'b0;
      default: run_d = 1'b0;
    endcase
  end

  // Wishbone slave: answer one cycle after the request
  wire req = wb_cyc_i & wb_stb_i & ~ack_q;
  wire wr_go = wb_cyc_i & wb_stb_i & wb_we_i & ack_q;
  wire hit_wdog = (wb_adr_i == ADR_WDOG);
  wire hit_mem = (wb_adr_i == ADR_MEM);
  wire hit_ctrl = (wb_adr_i == ADR_CTRL);
  wire hit_stat = (wb_adr_i == ADR_STAT);
  wire lo_ok = &wb_sel_i[1:0];
  wire wr_word = wr_go & (hit_wdog | hit_mem) & lo_ok;
  // self writes denied by config protection; programmer bypasses it
  wire wr_block = pcfg_q.cfg_wp & ~prog_access;
  wire wr_ok = wr_word & ~wr_block;
  wire wr_ctl0 = wr_go & hit_ctrl & wb_sel_i[0];
  wire wr_ctl1 = wr_go & hit_ctrl & wb_sel_i[1];
  wire rej_clr = wr_go & hit_stat & wb_sel_i[0] & wb_dat_i[STA_REJ];

  // memory word write filter
  wire [WORD_W-1:0] m_cur = nvm_mem_word | MEM_UNIMPL;
  wire [WORD_W-1:0] m_new = wb_dat_i[WORD_W-1:0] | MEM_UNIMPL;
  // sticky bits may only go from one to zero
  wire [WORD_W-1:0] m_stk =
    m_new & (m_cur | ~MEM_STICKY);
  wire lv_keep = lv_iface_active & ~m_stk[LV_PROG_BIT];
  wire bsz_keep = ~m_cur[BOOT_EN_N_BIT];
  wire [WORD_W-1:0] m_flt;
  assign m_flt[LV_PROG_BIT] =
    lv_keep ? m_cur[LV_PROG_BIT] : m_stk[LV_PROG_BIT];
  assign m_flt[LV_PROG_BIT-1:BSZ_LSB+3] =
    m_stk[LV_PROG_BIT-1:BSZ_LSB+3];
  assign m_flt[BSZ_LSB +: 3] =
    bsz_keep ? m_cur[BSZ_LSB +: 3] : m_stk[BSZ_LSB +: 3];
  wire [WORD_W-1:0] w_new = wb_dat_i[WORD_W-1:0] | WDOG_UNIMPL;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_valid_q <= 1'b0;
      wr_mem_q <= 1'b0;
      wr_data_q <= '0;
    end else begin
      wr_valid_q <= wr_ok;
      if (wr_ok) begin
        wr_mem_q <= hit_mem;
        wr_data_q <= hit_mem ? m_flt : w_new;
      end
    end
  end

  // runtime window and period, writable only where soft control allowed
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      soft_en_q <= 1'b0;
      win_rt_q <= '0;
      per_rt_q <= '0;
      run_q <= 1'b0;
    end else begin
      run_q <= run_d & ~load_en;
      if (load_en) begin
        win_rt_q <= w_dec.window;
        per_rt_q <= w_dec.period;
      end else begin
        if (wr_ctl0) begin
          soft_en_q <= wb_dat_i[CTL_SOFT_EN];
        end
        if (wr_ctl0 & wcfg_q.win_soft) begin
          win_rt_q <= wb_dat_i[CTL_WIN_LSB +: 3];
        end
        if (wr_ctl1 & wcfg_q.per_soft) begin
          per_rt_q <= wb_dat_i[CTL_PER_LSB +: 5];
        end
      end
    end
  end

  // rejected-write flag: a new rejection beats a clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rej_q <= 1'b0;
    end else if (wr_word & wr_block) begin
      rej_q <= 1'b1;
    end else if (rej_clr) begin
      rej_q <= 1'b0;
    end
  end

  // read data
  wire [31:0] rd_ctrl = {19'h0_0000, per_rt_q, 1'b0, win_rt_q,
    3'h0, soft_en_q};
  wire [7:0] rd_prot = {3'h0, pcfg_q.lv_prog_en, pcfg_q.store_wp,
    pcfg_q.cfg_wp, pcfg_q.boot_wp, pcfg_q.app_wp};
  wire [31:0] rd_stat = {pcfg_q.boot_words, rd_prot, 5'h00,
    (state_q == ST_HELD), run_q, rej_q};
  wire [31:0] rd_mux =
    hit_wdog ? {18'h0_0000, wimg_q} :
    hit_mem ? {18'h0_0000, mimg_q} :
    hit_ctrl ? rd_ctrl :
    hit_stat ? rd_stat : 32'h0000_0000;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else begin
      ack_q <= req;
      if (req) begin
        dat_q <= rd_mux;
      end
    end
  end

  // self-write permission check for the flash controller
  wire [15:0] sw_ext = 16'(sw_addr);
  wire in_boot = pcfg_q.boot_en & (sw_ext < pcfg_q.boot_words);
  wire in_store = pcfg_q.store_en & (sw_addr >= STORE_BASE);
  assign sw_deny = sw_req & (sw_cfg ? pcfg_q.cfg_wp :
    in_boot ? pcfg_q.boot_wp :
    in_store ? pcfg_q.store_wp :
    pcfg_q.app_wp);

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign nvm_wr_valid = wr_valid_q;
  assign nvm_wr_mem = wr_mem_q;
  assign nvm_wr_data = wr_data_q;
  assign wdog_cfg = wcfg_q;
  assign prot_cfg = pcfg_q;
  assign wdog_run = run_q;
  assign wdog_window_runtime = win_rt_q;
  assign wdog_period_runtime = per_rt_q;

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_held;
    (state_q == ST_HELD) ##1 (state_q == ST_HELD);
  endsequence
  sequence s_mem_write_lv;
    wr_ok & hit_mem & lv_iface_active;
  endsequence

  AST_CLK_LF: assert property (
    load_en && ccs == CLK_LF |=> wcfg_q.clk_sel == CLK_LF)
    else $error("clock select not low-frequency");
  AST_WIN_OPEN: assert property (
    load_en && cws[2:1] == 2'b11 |=> wcfg_q.window == WIN_OPEN
      && wcfg_q.win_soft && !wcfg_q.win_keyed)
    else $error("open window decode wrong");
  AST_RUN_ON: assert property (
    s_held and wcfg_q.mode == MODE_ON |=> wdog_run)
    else $error("watchdog not running in mode on");
  AST_RUN_SLEEP: assert property (
    s_held ##0 (wcfg_q.mode == MODE_AWAKE && core_sleep)
      |=> !wdog_run)
    else $error("watchdog ran during sleep");
  AST_RUN_SOFT: assert property (
    state_q == ST_HELD && wcfg_q.mode == MODE_SOFT
      |=> wdog_run == $past(soft_en_q))
    else $error("soft mode ignores enable");
  AST_RUN_OFF: assert property (
    wcfg_q.mode == MODE_OFF |=> !wdog_run)
    else $error("watchdog ran while off");
  AST_PER_ERASED: assert property (
    load_en && cps == PER_ERASED |=> wcfg_q.period == PER_DEFAULT
      && wcfg_q.per_soft && per_rt_q == PER_DEFAULT)
    else $error("erased period not defaulted");
  AST_LV_KEEP: assert property (
    s_mem_write_lv ##0 !m_cur[LV_PROG_BIT] == 1'b0
      |=> nvm_wr_valid && nvm_wr_data[LV_PROG_BIT])
    else $error("low voltage bit cleared from interface");
  AST_STICKY: assert property (
    wr_ok && hit_mem |=> nvm_wr_valid &&
      (nvm_wr_data & MEM_STICKY & ~$past(m_cur)) == '0)
    else $error("sticky bit returned to one");
  AST_CFG_BLOCK: assert property (
    wr_word && pcfg_q.cfg_wp && !prog_access
      |=> !nvm_wr_valid ##1 rej_q)
    else $error("config self write not blocked");
  AST_BOOT_HALF: assert property (
    state_q == ST_HELD |-> pcfg_q.boot_words <= HALF_WORDS)
    else $error("boot size above half memory");
  AST_HOLD: assert property (
    s_held |-> $stable(wcfg_q) && $stable(pcfg_q))
    else $error("settings changed after load");
endmodule // cwnp_config_loader

//--- cwnp_flash_model.sv
// cwnp_flash_model: flash array holding the two config word images
// assumes the loader's program port; preset and erase come from the bench
`timescale 1ns/1ps
module cwnp_flash_model
  import cwnp_pkg::*;
(
  input wire logic clk,
  input wire logic preset,
  input wire logic erase,
  input wire logic [WORD_W-1:0] preset_wdog,
  input wire logic [WORD_W-1:0] preset_mem,
  input wire logic wr_valid,
  input wire logic wr_mem,
  input wire logic [WORD_W-1:0] wr_data,
  output logic [WORD_W-1:0] wdog_word,
  output logic [WORD_W-1:0] mem_word,
  output int n_wr
);
  // erased cells read as ones, so a blank part starts all high
  initial begin
    wdog_word = '1;
    mem_word = '1;
    n_wr = 0;
  end
  always @(posedge clk) begin
    if (erase) begin
      wdog_word <= '1;
      mem_word <= '1;
    end else if (preset) begin
      wdog_word <= preset_wdog;
      mem_word <= preset_mem;
    end else if (wr_valid) begin
      // images are levels held until rewritten
      n_wr <= n_wr + 1;
      if (wr_mem) mem_word <= wr_data;
      else wdog_word <= wr_data;
    end
  end
endmodule // cwnp_flash_model

//--- cwnp_config_loader_bench.sv
// cwnp_config_loader_bench: self-checking bench for the config loader
// assumes the flash model as far side and a 40 MHz clock
`timescale 1ns/1ps
module cwnp_config_loader_bench
  import cwnp_pkg::*;
;
  localparam int UPM = 1536;
  logic clk, sys_rst, cyc, stb, we, ack, core_sleep, lv_iface, prog_acc;
  logic rpe, sw_req, sw_cfg, sw_deny, wr_valid, wr_mem, run, preset, erase;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r, rd;
  logic [14:0] sw_addr;
  logic [13:0] wr_data, pw, pm, wword, mword, w, m, nm;
  logic [2:0] win_rt, nw;
  logic [4:0] per_rt, np;
  cwnp_wdog_t wcfg, ew;
  cwnp_prot_t pcfg, ep;
  int n_wr, nwr, mismatches, n_tests, cyc_cnt;
  logic er, lvi, drop;
  logic [2:0] ccode [4] = '{3'h0, 3'h1, 3'h7, 3'h2};
  logic [4:0] pcode [4] = '{5'h1F, 5'h12, 5'h00, 5'h13};
  logic [2:0] wcode [4] = '{3'h7, 3'h6, 3'h0, 3'h5};

  cwnp_config_loader #(.UPM_WORDS(UPM), .STORE_WORDS(128), .PA_W(15)) dut_u (
    .clk(clk), .sys_rst(sys_rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .nvm_wdog_word(wword),
    .nvm_mem_word(mword), .reset_pin_enable(rpe), .lv_iface_active(lv_iface),
    .prog_access(prog_acc), .core_sleep(core_sleep), .sw_req(sw_req),
    .sw_addr(sw_addr), .sw_cfg(sw_cfg), .sw_deny(sw_deny),
    .nvm_wr_valid(wr_valid), .nvm_wr_mem(wr_mem), .nvm_wr_data(wr_data),
    .wdog_cfg(wcfg), .prot_cfg(pcfg), .wdog_run(run),
    .wdog_window_runtime(win_rt), .wdog_period_runtime(per_rt));
  cwnp_flash_model flash_u (
    .clk(clk), .preset(preset), .erase(erase), .preset_wdog(pw),
    .preset_mem(pm), .wr_valid(wr_valid), .wr_mem(wr_mem),
    .wr_data(wr_data), .wdog_word(wword), .mem_word(mword), .n_wr(n_wr));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic cwnp_wdog_t exp_wdog(input logic [13:0] c);
    cwnp_wdog_t e;
    e = '0;
    case (c[13:11])
      3'h0: e.clk_sel = CLK_MF;
      3'h1: e.clk_sel = CLK_LF;
      3'h7: e.clk_sel = CLK_SOFT;
      default: e.clk_sel = CLK_RSVD;
    endcase
    e.win_soft = (c[10:9] == 2'h3);
    e.window = e.win_soft ? WIN_OPEN : c[10:8];
    e.win_keyed = !e.win_soft;
    e.mode = cwnp_mode_t'(c[6:5]);
    e.per_soft = (c[4:0] == PER_ERASED);
    e.period = e.per_soft ? PER_DEFAULT : c[4:0];
    e.div_shift = {1'b0, e.period} + PER_SHIFT_BASE;
    return e;
  endfunction

  function automatic cwnp_prot_t exp_prot(input logic [13:0] c);
    cwnp_prot_t e;
    e.lv_prog_en = c[13];
    e.hv_prog_req = !c[13];
    e.reset_pin_fixed = c[13];
    e.store_en = !c[4];
    e.store_wp = !c[11] && !c[4];
    e.cfg_wp = !c[9];
    e.boot_en = !c[3];
    e.boot_wp = !c[8] && !c[3];
    e.app_wp = !c[7];
    e.boot_words = c[3] ? 16'h0000 : (c[2:0] == 3'h7 ? 16'h0200 : 16'h0400);
    if (e.boot_words > 16'(UPM / 2)) e.boot_words = 16'(UPM / 2);
    return e;
  endfunction

  // image the flash should hold after a memory word write
  function automatic logic [13:0] filt(input logic [13:0] c,
                                       input logic [13:0] n, input logic l);
    logic [13:0] r;
    r = (n & ~MEM_STICKY) | (c & n & MEM_STICKY);
    if (l) r[13] = n[13] | c[13];
    if (!c[3]) r[2:0] = c[2:0];
    return r;
  endfunction

  task automatic cmp(input string nm_, input logic [31:0] e,
                     input logic [31:0] g, input logic [31:0] k);
    n_tests++;
    if (((g ^ e) & k) !== 32'h0000_0000) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm_, e, g);
    end
  endtask

  task automatic wb(input logic w_, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w_;
    adr <= a;
    dat_w <= d;
    // ack and read data are taken at the rising edge that samples ack high
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (ack !== 1'b1) mismatches++;
    r = dat_r;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  task automatic query(input logic c, input logic [14:0] a, input logic e);
    sw_req <= 1'b1;
    sw_cfg <= c;
    sw_addr <= a;
    @(negedge clk);
    cmp("sw_deny", {31'h0, e}, {31'h0, sw_deny}, 32'h0000_0001);
    @(posedge clk);
  endtask

  task automatic boot(input logic [13:0] a, input logic [13:0] b,
                      input logic p);
    preset <= p;
    pw <= a;
    pm <= b;
    sys_rst <= 1'b1;
    repeat (16) @(posedge clk);
    preset <= 1'b0;
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic check_cfg();
    // reset pin is fixed by low voltage mode or by its own enable bit
    ep.reset_pin_fixed = ep.lv_prog_en | rpe;
    cmp("wdog_cfg", 32'(ew), 32'(wcfg), 32'hFFFF_FFFF);
    cmp("prot_cfg", 32'(ep), 32'(pcfg),
        32'hFFFF_FFFF);
  endtask

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // hang guard, about eighteen times the expected run length
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      mismatches++;
      wrap_up();
    end
  end

  initial begin
    {sys_rst, cyc, stb, we, core_sleep, lv_iface, prog_acc} = 7'h40;
    {rpe, sw_req, sw_cfg, preset, erase} = 5'h00;
    {adr, sel, dat_w, sw_addr, pw, pm} = '0;
    sel = 4'hF;
    mismatches = 0;
    n_tests = 0;
    cyc_cnt = 0;
    void'($urandom(32'h0000_b60b));
    for (int i = 0; i < 16; i++) begin
      w = 14'($urandom);
      m = 14'($urandom);
      if (i < 4) begin
        w[13:11] = ccode[i];
        w[10:8] = wcode[i];
        w[6:5] = 2'(i);
        w[4:0] = pcode[i];
        m[3:0] = {1'b0, 3'(i + 6)};
      end
      rpe <= 1'($urandom);
      ew = exp_wdog(w);
      ep = exp_prot(m);
      boot(w, m, 1'b1);
      check_cfg();
      wb(1'b0, ADR_WDOG, 32'h0, rd);
      cmp("wdog_word", {18'h0, w | WDOG_UNIMPL}, rd, 32'hFFFF_FFFF);
      wb(1'b0, ADR_MEM, 32'h0, rd);
      cmp("mem_word", {18'h0, m | MEM_UNIMPL}, rd, 32'hFFFF_FFFF);
      wb(1'b0, ADR_STAT, 32'h0, rd);
      cmp("status", {ep.boot_words, 3'h0, ep.lv_prog_en, ep.store_wp, ep.cfg_wp,
          ep.boot_wp, ep.app_wp, 8'h00}, rd, 32'hFFFF_1F00);
      wb(1'b0, 8'h10, 32'h0, rd);
      cmp("unmapped", 32'h0, rd, 32'hFFFF_FFFF);
      for (int k = 0; k < 4; k++) begin
        core_sleep <= k[1];
        nw = 3'($urandom);
        np = 5'($urandom_range(18));
        wb(1'b1, ADR_CTRL, {19'h0, np, 1'b0, nw, 3'h0, k[0]}, rd);
        @(posedge clk);
        @(negedge clk);
        case (ew.mode)
          MODE_ON: er = 1'b1;
          MODE_AWAKE: er = !k[1];
          MODE_SOFT: er = k[0];
          default: er = 1'b0;
        endcase
        cmp("wdog_run", {31'h0, er}, {31'h0, run}, 32'h1);
        cmp("win_rt", {29'h0, ew.win_soft ? nw : ew.window}, {29'h0, win_rt},
            32'h7);
        cmp("per_rt", {27'h0, ew.per_soft ? np : ew.period}, {27'h0, per_rt},
            32'h1F);
        @(posedge clk);
      end
      query(1'b1, 15'h0000, ep.cfg_wp);
      query(1'b0, 15'h0000, ep.boot_en ? ep.boot_wp : ep.app_wp);
      query(1'b0, 15'h02BC, (ep.boot_en && ep.boot_words > 16'h02BC) ?
            ep.boot_wp : ep.app_wp);
      query(1'b0, 15'h05AA, ep.store_en ? ep.store_wp : ep.app_wp);
      query(1'b0, 15'h03E8, ep.app_wp);
      sw_req <= 1'b0;
      nm = 14'($urandom);
      lvi = 1'($urandom);
      lv_iface <= lvi;
      prog_acc <= 1'($urandom);
      @(posedge clk);
      drop = ep.cfg_wp && !prog_acc;
      nwr = n_wr;
      wb(1'b1, ADR_MEM, {18'h0, nm}, rd);
      repeat (2) @(posedge clk);
      cmp("flash_writes", 32'(drop ? nwr : nwr + 1), 32'(n_wr), 32'hFFFF_FFFF);
      if (!drop) cmp("mem_image", {18'h0, filt(m, nm, lvi)}, {18'h0, mword},
                     32'h0000_2B9F);
      wb(1'b0, ADR_STAT, 32'h0, rd);
      cmp("reject", {31'h0, drop}, rd, 32'h0000_0001);
      wb(1'b0, ADR_MEM, 32'h0, rd);
      cmp("held_word", {18'h0, m | MEM_UNIMPL}, rd, 32'hFFFF_FFFF);
      check_cfg();
      $display("case %0d done", i);
    end
    erase <= 1'b1;
    @(posedge clk);
    erase <= 1'b0;
    ew = exp_wdog(14'h3FFF);
    ep = exp_prot(14'h3FFF);
    boot(14'h0000, 14'h0000, 1'b0);
    check_cfg();
    $display("erase case done");
    wrap_up();
  end
endmodule // cwnp_config_loader_bench
